/* include/mgmt_defines.svh */
/*
 * constants for the two-wire management port: addresses, page layout,
 * monitor and flag locations, timing counts.
 * assumes a 200 MHz system clock on both ends.
 */
// Contract
// (R1) host generates serial clock, module never does
// (R2) writes taken on rising edge, protected untouched
// (R3) read data changes on falling edge
// (R4) start and stop framed and detected
// (R5) byte memory from zero, random and sequential
// (R6) lower 128 bytes fixed, upper region paged
// (R7) lower, pages 00 and 03 always present
// (R8) page 02 is host read/write storage
// (R9) slave address A0h used by both ends
// (R10) flags and monitors live in lower region
// (R11) host reads flags after attention request
// (R12) monitors updated continuously
// (R13) alarm/warning flags on out-of-range monitors
// (R14) byte pointer advances after each byte
// (R15) attention low while flags set, released after clear
`ifndef MGMT_DEFINES_SVH
`define MGMT_DEFINES_SVH

`define DEV_ADDR        7'h50
`define LOWER_TOP       8'h7f
`define PAGE_SEL_ADDR   8'h7f
`define FLAG_ADDR       8'h03
`define FLAG_CLR_ADDR   8'h04
`define MON_BASE        8'h16
`define MON_COUNT       5
`define CTRL_LO_ADDR    8'h56
`define PAGE_00         2'h0
`define PAGE_02         2'h2
`define PAGE_03         2'h3
`define HI_TH_BASE      7'h00
`define LO_TH_BASE      7'h08
`define MON_PERIOD_NS   1000
`define CLK_PERIOD_NS   5
`define MON_CYCLES      (`MON_PERIOD_NS / `CLK_PERIOD_NS)
`define SCL_HALF_NS     250
`define SCL_HALF_CYCLES (`SCL_HALF_NS / `CLK_PERIOD_NS)

`endif

/* include/mgmt_pkg.sv */
/*
 * types shared by both ends of the management link.
 * assumes nothing beyond the defines header.
 */
package mgmt_pkg;
	typedef enum logic [2:0] {S_IDLE, S_ADDR, S_ACK, S_DATA, S_DACK, S_WAIT} slave_state_type;
	typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_ACK, H_STOP, H_DONE} host_state_type;
endpackage

/* include/mgmt_link_if.sv */
/*
 * two-wire management link between host and module.
 * resolves the open-drain data line and the host-driven clock.
 */
`timescale 1ns/100ps
interface mgmt_link_if;
	logic scl_out;
	logic scl_oe;
	logic host_sda_out;
	logic host_sda_oe;
	logic mod_sda_out;
	logic mod_sda_oe;
	logic scl;
	logic sda;

	// open-drain with pull-up
	assign scl = scl_oe ? scl_out : 1'b1;
	assign sda = (host_sda_oe && !host_sda_out) || (mod_sda_oe && !mod_sda_out) ? 1'b0 : 1'b1;

	modport host_end (output scl_out, output scl_oe, output host_sda_out, output host_sda_oe,
		input scl, input sda);
	modport module_end (output mod_sda_out, output mod_sda_oe, input scl, input sda);
endinterface

/* rtl/mgmt_module_end.sv */
/*
 * module side of the management port: two-wire slave, paged byte memory,
 * live monitors, threshold flags and attention request.
 * assumes the host clocks the link; scl and sda are asynchronous to clk_in.
 */
`timescale 1ns/100ps
`include "mgmt_defines.svh"
module mgmt_module_end
	import mgmt_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        sys_rst_in,
	mgmt_link_if.module_end  link,
	input  wire logic [79:0] monitor_in,
	output logic             attention_request_n_out,
	output logic [7:0]       ctrl_out
);
	slave_state_type state_q;
	logic [1:0]  scl_sync_q, sda_sync_q;
	logic        scl_prev_q, sda_prev_q;
	logic [7:0]  shift_q;
	logic [3:0]  bit_cnt_q;
	logic        rd_q;
	logic        addr_phase_q;
	logic [7:0]  ptr_q;
	logic [1:0]  page_q;
	logic [7:0]  flags_q;
	logic [7:0]  ctrl_q;
	logic        sda_drv_q;
	logic        sda_oe_q;
	logic        attn_q;
	logic [7:0]  tx_q;
	logic [15:0] mon_q [0:`MON_COUNT-1];
	logic [7:0]  page0_mem [0:127];
	logic [7:0]  page2_mem [0:127];
	logic [7:0]  page3_mem [0:127];
	logic [15:0] mon_cnt_q;

	// only the second stage feeds edge and data logic
	wire scl_s      = scl_sync_q[1];
	wire sda_s      = sda_sync_q[1];
	wire scl_rise   = scl_s && !scl_prev_q;
	wire scl_fall   = !scl_s && scl_prev_q;
	// (R4) start stop detect
	wire start_det  = scl_s && scl_prev_q && sda_prev_q && !sda_s;
	wire stop_det   = scl_s && scl_prev_q && !sda_prev_q && sda_s;
	wire upper      = ptr_q[7];
	wire [6:0] off  = ptr_q[6:0];
	// (R10) monitor bytes in lower page
	wire in_mon     = (ptr_q >= `MON_BASE) && (ptr_q < `MON_BASE + 8'(2 * `MON_COUNT));
	wire [7:0] mon_idx = ptr_q - `MON_BASE;
	wire [7:0] mon_byte = mon_idx[0] ? mon_q[mon_idx[3:1]][7:0] : mon_q[mon_idx[3:1]][15:8];
	// (R6) (R7) lower fixed, upper paged
	wire [7:0] up_byte  = (page_q == `PAGE_00) ? page0_mem[off] :
		(page_q == `PAGE_02) ? page2_mem[off] :
		(page_q == `PAGE_03) ? page3_mem[off] : 8'h00;
	wire [7:0] lo_byte  = (ptr_q == `FLAG_ADDR) ? flags_q :
		(ptr_q == `PAGE_SEL_ADDR) ? {6'h00, page_q} :
		(ptr_q == `CTRL_LO_ADDR) ? ctrl_q :
		in_mon ? mon_byte : 8'h00;
	wire [7:0] rd_byte  = upper ? up_byte : lo_byte;
	wire [7:0] rx_byte  = {shift_q[6:0], sda_s};
	wire       wr_fire  = scl_rise && state_q == S_DATA && !rd_q && bit_cnt_q == 4'h7 && !addr_phase_q;
	// (R2) only unprotected locations writable
	wire       wr_page_sel = wr_fire && ptr_q == `PAGE_SEL_ADDR;
	wire       wr_ctrl  = wr_fire && ptr_q == `CTRL_LO_ADDR;
	wire       wr_clr   = wr_fire && ptr_q == `FLAG_CLR_ADDR;
	wire       wr_page2 = wr_fire && upper && page_q == `PAGE_02;
	wire       wr_page3 = wr_fire && upper && page_q == `PAGE_03;

	// (R13) per monitor alarm against thresholds
	logic [`MON_COUNT-1:0] hi_hit, lo_hit;
	genvar gi;
	generate
		for (gi = 0; gi < `MON_COUNT; gi++) begin : g_th
			assign hi_hit[gi] = mon_q[gi] > {page3_mem[`HI_TH_BASE + 7'(gi)], 8'h00};
			assign lo_hit[gi] = mon_q[gi] < {page3_mem[`LO_TH_BASE + 7'(gi)], 8'h00};
		end
	endgenerate
	wire [7:0] flag_set = {1'b0, hi_hit[4:2] | lo_hit[4:2], 1'b0, 1'b0, |hi_hit[1:0], |lo_hit[1:0]};

	// input synchronisers
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], link.scl};
			sda_sync_q <= {sda_sync_q[0], link.sda};
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// (R12) periodic monitor refresh
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mon_cnt_q <= 16'h0000;
			for (int i = 0; i < `MON_COUNT; i++)
				mon_q[i] <= 16'h0000;
		end else begin
			mon_cnt_q <= (mon_cnt_q == 16'(`MON_CYCLES - 1)) ? 16'h0000 : mon_cnt_q + 16'h0001;
			if (mon_cnt_q == 16'h0000)
				for (int i = 0; i < `MON_COUNT; i++)
					mon_q[i] <= monitor_in[16*i +: 16];
		end
	end

	// (R13) sticky flags, set beats clear
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			flags_q <= 8'h00;
		else
			flags_q <= (wr_clr ? (flags_q & ~rx_byte) : flags_q) | flag_set;
	end

	// (R15) attention while any flag
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			attn_q <= 1'b1;
		else
			attn_q <= ~|flags_q;
	end

	// user page storage
	always_ff @(posedge clk_in) begin
		// (R8) page 02 read/write
		if (wr_page2)
			page2_mem[off] <= rx_byte;
	end

	// fixed pages: thresholds start wide open, so after reset a flag fires only for a monitor above ff00h
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < 128; i++) begin
				page0_mem[i] <= 8'h00;
				page3_mem[i] <= (7'(i) < `LO_TH_BASE) ? 8'hff : 8'h00;
			end
		end else if (wr_page3) begin
			page3_mem[off] <= rx_byte;
		end
	end

	// slave protocol engine
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q      <= S_IDLE;
			shift_q      <= 8'h00;
			bit_cnt_q    <= 4'h0;
			rd_q         <= 1'b0;
			addr_phase_q <= 1'b0;
			ptr_q        <= 8'h00;
			page_q       <= `PAGE_00;
			ctrl_q       <= 8'h00;
			sda_drv_q    <= 1'b1;
			sda_oe_q     <= 1'b0;
			tx_q         <= 8'h00;
		end else if (start_det) begin
			state_q   <= S_ADDR;
			bit_cnt_q <= 4'h0;
			sda_oe_q  <= 1'b0;
		end else if (stop_det) begin
			state_q  <= S_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			if (wr_page_sel)
				page_q <= rx_byte[1:0];
			if (wr_ctrl)
				ctrl_q <= rx_byte;
			case (state_q)
				S_ADDR: begin
					if (scl_rise) begin
						shift_q   <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					// (R9) match device address
					if (scl_fall && bit_cnt_q == 4'h8) begin
						if (shift_q[7:1] == `DEV_ADDR) begin
							rd_q         <= shift_q[0];
							addr_phase_q <= !shift_q[0];
							sda_oe_q     <= 1'b1;
							sda_drv_q    <= 1'b0;
							tx_q         <= rd_byte;
							state_q      <= S_ACK;
						end else
							state_q <= S_WAIT;
					end
				end
				S_ACK, S_DACK: begin
					// (R3) drive on falling edge
					if (scl_fall) begin
						bit_cnt_q <= 4'h0;
						state_q   <= S_DATA;
						sda_oe_q  <= rd_q;
						sda_drv_q <= tx_q[7];
						tx_q      <= {tx_q[6:0], 1'b1};
					end
				end
				S_DATA: begin
					// (R2) sample on rising edge
					if (scl_rise) begin
						shift_q   <= rx_byte;
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (addr_phase_q && bit_cnt_q == 4'h7) begin
							ptr_q        <= rx_byte;
							addr_phase_q <= 1'b0;
						end else if (bit_cnt_q == 4'h7 && !rd_q) begin
							// (R5) (R14) pointer advances
							ptr_q <= ptr_q + 8'h01;
						end
					end
					if (scl_fall && bit_cnt_q != 4'h8) begin
						sda_drv_q <= tx_q[7];
						tx_q      <= {tx_q[6:0], 1'b1};
					end
					if (scl_fall && bit_cnt_q == 4'h8) begin
						// (R14) read pointer advances per byte
						if (rd_q)
							ptr_q <= ptr_q + 8'h01;
						sda_oe_q  <= !rd_q;
						sda_drv_q <= 1'b0;
						state_q   <= rd_q ? S_WAIT : S_DACK;
					end
				end
				S_WAIT: begin
					// master ack on read: continue sequentially
					if (rd_q && scl_rise && !sda_s)
						state_q <= S_DACK;
					if (scl_rise)
						tx_q <= rd_byte;
					if (rd_q && scl_rise && sda_s)
						rd_q <= 1'b0;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	assign link.mod_sda_out = sda_drv_q;
	assign link.mod_sda_oe  = sda_oe_q;
	assign attention_request_n_out = attn_q;
	assign ctrl_out = ctrl_q;
endmodule

/* rtl/mgmt_host_end.sv */
/*
 * host side of the management port: two-wire master issuing one-byte
 * writes and reads (pointer set then repeated start read).
 * assumes the module end answers at the fixed slave address.
 */
`timescale 1ns/100ps
`include "mgmt_defines.svh"
module mgmt_host_end
	import mgmt_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       sys_rst_in,
	mgmt_link_if.host_end   link,
	input  wire logic       req_in,
	input  wire logic       rd_in,
	input  wire logic [7:0] addr_in,
	input  wire logic [7:0] wdata_in,
	output logic            busy_out,
	output logic            done_out,
	output logic            nack_out,
	output logic [7:0]      rdata_out
);
	host_state_type state_q;
	logic [15:0] tick_q;
	logic        phase_q;
	logic [3:0]  bit_q;
	logic [1:0]  byte_q;
	logic [7:0]  sh_q;
	logic        scl_q, sda_q, busy_q, done_q, nack_q, rd_q;
	logic [7:0]  addr_q, wd_q, rdat_q;
	logic [1:0]  sda_sync_q;

	wire tick     = tick_q == 16'(`SCL_HALF_CYCLES - 1);
	wire sda_s    = sda_sync_q[1];
	wire last_byte = rd_q ? (byte_q == 2'h3) : (byte_q == 2'h2);
	// byte sequence: addr/w, pointer, (data | restart addr/r, data)
	wire [7:0] next_tx = (byte_q == 2'h0) ? {`DEV_ADDR, 1'b0} :
		(byte_q == 2'h1) ? (rd_q ? {`DEV_ADDR, 1'b1} : wd_q) : 8'hff;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			sda_sync_q <= 2'h3;
		else
			sda_sync_q <= {sda_sync_q[0], link.sda};
	end

	// (R1) host drives serial clock
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_q <= H_IDLE; tick_q <= 16'h0000; phase_q <= 1'b0;
			bit_q <= 4'h0; byte_q <= 2'h0; sh_q <= 8'h00;
			scl_q <= 1'b1; sda_q <= 1'b1; busy_q <= 1'b0; done_q <= 1'b0;
			nack_q <= 1'b0; rd_q <= 1'b0; addr_q <= 8'h00; wd_q <= 8'h00; rdat_q <= 8'h00;
		end else begin
			done_q <= 1'b0;
			tick_q <= (state_q == H_IDLE || tick) ? 16'h0000 : tick_q + 16'h0001;
			case (state_q)
				H_IDLE: if (req_in) begin
					rd_q <= rd_in; addr_q <= addr_in; wd_q <= wdata_in;
					busy_q <= 1'b1; nack_q <= 1'b0; byte_q <= 2'h0; phase_q <= 1'b0;
					bit_q <= 4'h0;
					state_q <= H_START;
				end
				// (R4) start: sda falls while scl high
				// clock low and data released first, so a repeated start frees the slave's ack
				H_START: if (tick) begin
					bit_q <= bit_q + 4'h1;
					if (bit_q == 4'h0) begin
						scl_q <= 1'b0;
						sda_q <= 1'b1;
					end else if (bit_q == 4'h1) begin
						scl_q <= 1'b1;
					end else begin
						sda_q <= 1'b0; phase_q <= 1'b0; bit_q <= 4'h0;
						sh_q <= (byte_q == 2'h2) ? {`DEV_ADDR, 1'b1} : {`DEV_ADDR, 1'b0};
						state_q <= H_BIT;
					end
				end
				H_BIT: if (tick) begin
					scl_q <= phase_q;
					if (!phase_q) begin
						sda_q <= (rd_q && byte_q == 2'h3) ? 1'b1 : sh_q[7];
					end else begin
						sh_q <= {sh_q[6:0], sda_s};
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h7) state_q <= H_ACK;
					end
					phase_q <= !phase_q;
				end
				H_ACK: if (tick) begin
					scl_q <= phase_q;
					if (!phase_q)
						sda_q <= 1'b1; // release: slave ack, or host nack on last read
					else begin
						if (rd_q && byte_q == 2'h3) rdat_q <= sh_q;
						if (sda_s && !(rd_q && byte_q == 2'h3)) nack_q <= 1'b1;
						bit_q <= 4'h0;
						byte_q <= byte_q + 2'h1;
						sh_q <= (byte_q == 2'h0) ? addr_q : next_tx;
						if (last_byte || (sda_s && !(rd_q && byte_q == 2'h3)))
							state_q <= H_STOP;
						else if (rd_q && byte_q == 2'h1)
							state_q <= H_START;
						else
							state_q <= H_BIT;
					end
					phase_q <= !phase_q;
				end
				// (R4) stop: sda rises while scl high
				H_STOP: if (tick) begin
					if (!phase_q) begin
						scl_q <= 1'b0; sda_q <= 1'b0;
					end else
						scl_q <= 1'b1;
					phase_q <= !phase_q;
					if (phase_q) state_q <= H_DONE;
				end
				H_DONE: if (tick) begin
					sda_q <= 1'b1; busy_q <= 1'b0; done_q <= 1'b1; state_q <= H_IDLE;
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	assign link.scl_out      = scl_q;
	assign link.scl_oe       = 1'b1;
	assign link.host_sda_out = sda_q;
	assign link.host_sda_oe  = !sda_q;
	assign busy_out  = busy_q;
	assign done_out  = done_q;
	assign nack_out  = nack_q;
	assign rdata_out = rdat_q;
endmodule

/* verification/mgmt_link_assertions.sv */
/*
 * wire checks on the two-wire management link.
 * assumes one clock domain, reset active high, host-made serial clock.
 */
`timescale 1ns/100ps
module mgmt_link_assertions (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic mod_sda_oe,
	input wire logic mod_sda_out
);
	// module pulls the data line low
	wire logic mod_low;
	assign mod_low = mod_sda_oe && !mod_sda_out;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	scl_low_min_a: assert property ($fell(scl) |-> (!scl)[*8])
		else $error("serial clock low phase too short");
	scl_high_min_a: assert property ($rose(scl) |-> scl[*8])
		else $error("serial clock high phase too short");
	scl_low_bound_a: assert property ($fell(scl) |-> ##[40:60] scl)
		else $error("serial clock low phase too long");
	mod_change_low_a: assert property ($changed(mod_sda_oe) |-> !scl)
		else $error("module data changed while clock high");
	mod_hold_high_a: assert property ($rose(scl) |-> $stable(mod_low)[*8])
		else $error("module data not held while clock high");
	host_frame_a: assert property (scl && $past(scl) && $changed(sda) |-> $stable(mod_low))
		else $error("module made a frame condition");
	stop_release_a: assert property (scl && $past(scl) && $rose(sda) |=> (!mod_low)[*8])
		else $error("module drives data after stop");
	start_free_a: assert property (scl && $past(scl) && $fell(sda) |-> !mod_low)
		else $error("module pulled data at start");
endmodule

/* verification/tb_top.sv */
/*
 * bench joining host end and module end over the link interface.
 * assumes the host user side makes one transfer at a time.
 */
`timescale 1ns/100ps
`include "mgmt_defines.svh"
module tb_top;
	logic        clk_in     = 1'b0;
	logic        sys_rst_in = 1'b1;
	logic        req_in     = 1'b0;
	logic        rd_in      = 1'b0;
	logic [7:0]  addr_in    = 8'h00;
	logic [7:0]  wdata_in   = 8'h00;
	logic [79:0] monitor_in = 80'h0;
	wire logic       busy_out;
	wire logic       done_out;
	wire logic       nack_out;
	wire logic       attention_request_n_out;
	wire logic [7:0] rdata_out;
	wire logic [7:0] ctrl_out;
	int fails = 0;
	int cmp_count = 0;

	mgmt_link_if mgmt_link_if_i ();
	mgmt_host_end mgmt_host_end_i (
		.clk_in    (clk_in),
		.sys_rst_in(sys_rst_in),
		.link      (mgmt_link_if_i),
		.req_in    (req_in),
		.rd_in     (rd_in),
		.addr_in   (addr_in),
		.wdata_in  (wdata_in),
		.busy_out  (busy_out),
		.done_out  (done_out),
		.nack_out  (nack_out),
		.rdata_out (rdata_out)
	);
	mgmt_module_end mgmt_module_end_i (
		.clk_in                 (clk_in),
		.sys_rst_in             (sys_rst_in),
		.link                   (mgmt_link_if_i),
		.monitor_in             (monitor_in),
		.attention_request_n_out(attention_request_n_out),
		.ctrl_out               (ctrl_out)
	);
	mgmt_link_assertions mgmt_link_assertions_i (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.scl        (mgmt_link_if_i.scl),
		.sda        (mgmt_link_if_i.sda),
		.mod_sda_oe (mgmt_link_if_i.mod_sda_oe),
		.mod_sda_out(mgmt_link_if_i.mod_sda_out)
	);

	// free-running system clock
	always #2.5 clk_in = ~clk_in;

	// counts and verdict, then stop
	task automatic end_sim();
		$display("comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	task automatic cmp_bit(input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: expected %h, got %h", $time, exp, got);
		end
	endtask

	// one host transfer, bounded wait on the done pulse
	task automatic xfer(input logic rd, input logic [7:0] addr, input logic [7:0] data);
		int n;
		n = 0;
		req_in = 1'b1;
		rd_in = rd;
		addr_in = addr;
		wdata_in = data;
		@(negedge clk_in);
		req_in = 1'b0;
		while (done_out !== 1'b1 && n < 40000) begin
			@(negedge clk_in);
			n++;
		end
		if (n >= 40000) begin
			fails++;
			$display("Error at %0t: no done, expected %h, got %h", $time, 1'b1, done_out);
			end_sim();
		end
		cmp_bit(1'b0, nack_out);
	endtask

	task automatic test_idle();
		cmp_bit(1'b1, mgmt_link_if_i.scl);
		cmp_bit(1'b1, mgmt_link_if_i.sda);
		cmp_bit(1'b0, busy_out);
		$display("test idle done");
	endtask

	task automatic test_ctrl();
		xfer(1'b0, `CTRL_LO_ADDR, 8'ha5);
		cmp_byte(8'ha5, ctrl_out);
		$display("test ctrl write done");
	endtask

	// monitor changes after reset, read must see the new top byte
	task automatic test_monitor();
		monitor_in[15:0] = 16'hc33c;
		xfer(1'b1, `MON_BASE, 8'h00);
		cmp_byte(8'hc3, rdata_out);
		$display("test monitor read done");
	endtask

	task automatic test_page02();
		xfer(1'b0, `PAGE_SEL_ADDR, 8'h02);
		xfer(1'b0, 8'h80, 8'h5a);
		xfer(1'b1, 8'h80, 8'h00);
		cmp_byte(8'h5a, rdata_out);
		$display("test page 02 done");
	endtask

	// threshold below monitor raises a flag, clearing releases attention
	task automatic test_flags();
		xfer(1'b0, `PAGE_SEL_ADDR, 8'h03);
		xfer(1'b0, 8'h80, 8'h10);
		cmp_bit(1'b0, attention_request_n_out);
		xfer(1'b1, `FLAG_ADDR, 8'h00);
		cmp_byte(8'h02, rdata_out);
		xfer(1'b0, 8'h80, 8'hff);
		xfer(1'b0, `FLAG_CLR_ADDR, 8'h02);
		cmp_bit(1'b1, attention_request_n_out);
		$display("test flags done");
	endtask

	// reset for 8 cycles, then the scenarios
	initial begin
		repeat (8) @(negedge clk_in);
		sys_rst_in = 1'b0;
		@(negedge clk_in);
		test_idle();
		test_ctrl();
		test_monitor();
		test_page02();
		test_flags();
		end_sim();
	end
endmodule
